// >>> sbc_params.sv
// Basic control parameter bank of a servo drive with its stop and brake sequencer.
// Assumes a word-wide parameter access port driven by the communication front end.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_consts.svh"

module sbc_params #(
    parameter int MS_CYCLES = `SBC_MS_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Parameter access
    input wire logic parWrEn,
    input wire logic parRdEn,
    input wire logic [15:0] parAddr,
    input wire logic [15:0] parWrData,
    output logic [15:0] parRdData,
    output logic parAck,
    output logic parErr,
    // Drive events and status
    input wire logic servoEnableCmd,
    input wire logic fault1,
    input wire logic fault2,
    input wire logic fault3,
    input wire logic overtravel,
    input wire logic quickStop,
    input wire logic mainsLoss,
    input wire logic [15:0] motorSpeedRpm,
    input wire logic forwardCmd,
    // Encoder pulse output
    input wire logic stepPulse,
    input wire logic stepFwd,
    output logic pulseA,
    output logic pulseB,
    // Configuration outputs
    output logic [2:0] controlMode,
    output logic [2:0] absSystem,
    output logic turnCw,
    output logic keypadFaultDisp,
    // Stop and brake sequencer outputs
    output logic brake_output,
    output logic motorEnergized,
    output logic dynBrakeOn,
    output logic positionLock,
    output sbc_pkg::sbc_decel_t decelMode,
    output logic cmdAccept,
    output logic stopActive
);
    import sbc_pkg::*;

    // ==========================================================
    // Register tables
    localparam logic [15:0] ADDR_TBL [`SBC_NUM_RW] = '{
        `SBC_A_CTRL, `SBC_A_ABS, `SBC_A_DIR, `SBC_A_PHASE, `SBC_A_SOFF, `SBC_A_C2,
        `SBC_A_OVT, `SBC_A_C1, `SBC_A_BKON, `SBC_A_BKOFF, `SBC_A_BKSPD, `SBC_A_BKROT,
        `SBC_A_KPD, `SBC_A_MAINS, `SBC_A_QS};
    localparam logic [15:0] RST_TBL [`SBC_NUM_RW] = '{
        `SBC_R_CTRL, `SBC_R_ABS, `SBC_R_DIR, `SBC_R_PHASE, `SBC_R_SOFF, `SBC_R_C2,
        `SBC_R_OVT, `SBC_R_C1, `SBC_R_BKON, `SBC_R_BKOFF, `SBC_R_BKSPD, `SBC_R_BKROT,
        `SBC_R_KPD, `SBC_R_MAINS, `SBC_R_QS};
    localparam logic [15:0] MIN_TBL [`SBC_NUM_RW] = '{
        `SBC_MIN_ZERO, `SBC_MIN_ZERO, `SBC_MIN_ZERO, `SBC_MIN_ZERO, `SBC_MIN_SOFF,
        `SBC_MIN_C2, `SBC_MIN_ZERO, `SBC_MIN_ZERO, `SBC_MIN_ZERO, `SBC_MIN_BKOFF,
        `SBC_MIN_BKSPD, `SBC_MIN_BKROT, `SBC_MIN_ZERO, `SBC_MIN_ZERO, `SBC_MIN_ZERO};
    localparam logic [15:0] MAX_TBL [`SBC_NUM_RW] = '{
        `SBC_MAX_CTRL, `SBC_MAX_ABS, `SBC_MAX_BIT, `SBC_MAX_BIT, `SBC_MAX_SOFF,
        `SBC_MAX_C2, `SBC_MAX_OVT, `SBC_MAX_C1, `SBC_MAX_BKON, `SBC_MAX_BKOFF,
        `SBC_MAX_BKSPD, `SBC_MAX_BKROT, `SBC_MAX_BIT, `SBC_MAX_MAINS, `SBC_MAX_QS};
    localparam logic [14:0] AT_STOP_MASK = `SBC_AT_STOP_MASK;
    localparam logic [14:0] SIGNED_MASK = `SBC_SIGNED_MASK;
    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    // ==========================================================
    // Functions
    // Returns {hit, index}
    function automatic logic [4:0] lookupIdx(input logic [15:0] a);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < `SBC_NUM_RW; i++) begin
            if (ADDR_TBL[i] == a) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction : lookupIdx

    function automatic logic inRange(input logic [3:0] ix, input logic [15:0] d);
        logic ok;
        if (SIGNED_MASK[ix]) begin
            ok = ($signed(d) >= $signed(MIN_TBL[ix])) && ($signed(d) <= $signed(MAX_TBL[ix]));
        end else begin
            ok = (d >= MIN_TBL[ix]) && (d <= MAX_TBL[ix]);
        end
        if (ix == 4'(IX_QS) && d == `SBC_QS_UNASSIGNED) begin
            ok = 1'b0;
        end
        return ok;
    endfunction : inRange

    function automatic sbc_action_t act(input sbc_decel_t dc, input sbc_hold_t hd);
        return '{valid: 1'b1, decel: dc, hold: hd};
    endfunction : act

    function automatic sbc_action_t decodeServoOff(input logic [15:0] c);
        case (c)
            16'hfffc: return act(DEC_RAMP2, HOLD_DYNBRK);
            16'hfffd: return act(DEC_ZEROSPD, HOLD_DYNBRK);
            16'hfffe: return act(DEC_RAMP1, HOLD_DYNBRK);
            16'hffff: return act(DEC_DYNBRK, HOLD_DYNBRK);
            16'h0001: return act(DEC_RAMP1, HOLD_DEENERG);
            16'h0002: return act(DEC_DYNBRK, HOLD_DEENERG);
            default: return act(DEC_COAST, HOLD_DEENERG);
        endcase
    endfunction : decodeServoOff

    function automatic sbc_action_t decodeClass2(input logic [15:0] c);
        case (c)
            16'hfffb: return act(DEC_ZEROSPD, HOLD_DYNBRK);
            16'hfffc: return act(DEC_EMTORQ, HOLD_DYNBRK);
            16'hfffd: return act(DEC_RAMP2, HOLD_DYNBRK);
            16'hfffe: return act(DEC_RAMP1, HOLD_DYNBRK);
            16'hffff: return act(DEC_DYNBRK, HOLD_DYNBRK);
            16'h0001: return act(DEC_RAMP1, HOLD_DEENERG);
            16'h0002: return act(DEC_RAMP2, HOLD_DEENERG);
            16'h0003: return act(DEC_EMTORQ, HOLD_DEENERG);
            16'h0004: return act(DEC_DYNBRK, HOLD_DEENERG);
            default: return act(DEC_COAST, HOLD_DEENERG);
        endcase
    endfunction : decodeClass2

    function automatic sbc_action_t decodeOvertravel(input logic [15:0] c);
        case (c)
            16'h0001: return act(DEC_ZEROSPD, HOLD_POSLOCK);
            16'h0002: return act(DEC_ZEROSPD, HOLD_DEENERG);
            16'h0003: return act(DEC_RAMP2, HOLD_DEENERG);
            16'h0004: return act(DEC_RAMP2, HOLD_POSLOCK);
            16'h0005: return act(DEC_DYNBRK, HOLD_DEENERG);
            16'h0006: return act(DEC_DYNBRK, HOLD_DYNBRK);
            default: return act(DEC_COAST, HOLD_DEENERG);
        endcase
    endfunction : decodeOvertravel

    function automatic sbc_action_t decodeClass1(input logic [15:0] c);
        case (c)
            16'h0000: return act(DEC_COAST, HOLD_DEENERG);
            16'h0001: return act(DEC_DYNBRK, HOLD_DEENERG);
            default: return act(DEC_DYNBRK, HOLD_DYNBRK);
        endcase
    endfunction : decodeClass1

    function automatic sbc_action_t decodeQuick(input logic [15:0] c);
        case (c)
            16'h0001: return act(DEC_RAMP1, HOLD_DEENERG);
            16'h0002: return act(DEC_RAMP2, HOLD_DEENERG);
            16'h0003: return act(DEC_EMTORQ, HOLD_DEENERG);
            16'h0005: return act(DEC_RAMP1, HOLD_POSLOCK);
            16'h0006: return act(DEC_RAMP2, HOLD_POSLOCK);
            16'h0007: return act(DEC_EMTORQ, HOLD_POSLOCK);
            default: return act(DEC_COAST, HOLD_DEENERG);
        endcase
    endfunction : decodeQuick

    // ==========================================================
    // Parameter store and access
    logic [15:0] cfg_ff [`SBC_NUM_RW];
    logic [15:0] parRdData_ff;
    logic parAck_ff;
    logic parErr_ff;
    sbc_state_t state_ff;

    wire [4:0] hitIdx = lookupIdx(parAddr);
    wire rwHit = hitIdx[4];
    wire [3:0] accIdx = hitIdx[3:0];
    wire roRes = (parAddr == `SBC_A_REGEN_RES);
    wire roPwr = (parAddr == `SBC_A_REGEN_PWR);
    wire running = (state_ff != S_OFF);
    wire valueOk = inRange(accIdx, parWrData);
    wire stopLocked = AT_STOP_MASK[accIdx] && running;
    // RO words never reach the store, so a write to them is refused
    wire wrOk = parWrEn && rwHit && valueOk && !stopLocked;
    wire accErr = parWrEn ? !wrOk : !(rwHit || roRes || roPwr);
    wire [15:0] rdMux = rwHit ? cfg_ff[accIdx] :
                        roRes ? `SBC_V_REGEN_RES :
                        roPwr ? `SBC_V_REGEN_PWR : 16'h0000;

    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < `SBC_NUM_RW; i++) begin
                cfg_ff[i] <= RST_TBL[i];
            end
        end else if (wrOk) begin
            cfg_ff[accIdx] <= parWrData;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            parRdData_ff <= 16'h0000;
            parAck_ff <= 1'b0;
            parErr_ff <= 1'b0;
        end else begin
            parAck_ff <= parWrEn || parRdEn;
            parErr_ff <= (parWrEn || parRdEn) && accErr;
            if (parRdEn && !parWrEn) begin
                parRdData_ff <= rdMux;
            end
        end
    end

    // ==========================================================
    // Configuration fields
    wire [15:0] dirSel = cfg_ff[IX_DIR];
    wire [15:0] kpdSel = cfg_ff[IX_KPD];
    wire [15:0] mainsSel = cfg_ff[IX_MAINS];
    wire [15:0] bkOnDly = cfg_ff[IX_BKON];
    wire [15:0] bkOffDly = cfg_ff[IX_BKOFF];
    wire [15:0] bkSpdThr = cfg_ff[IX_BKSPD];
    wire [15:0] bkRotDly = cfg_ff[IX_BKROT];

    assign controlMode = cfg_ff[IX_CTRL][2:0];
    assign absSystem = cfg_ff[IX_ABS][2:0];

    logic turnCw_ff;
    logic fault3Prev_ff;
    logic keypad_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            turnCw_ff <= 1'b0;
            fault3Prev_ff <= 1'b0;
            keypad_ff <= 1'b0;
        end else begin
            turnCw_ff <= forwardCmd ? dirSel[0] : !dirSel[0];
            fault3Prev_ff <= fault3;
            // Set on a new class-3 fault; held while the fault stands
            keypad_ff <= (fault3 && !fault3Prev_ff && kpdSel == 16'h0000) ||
                         (keypad_ff && fault3);
        end
    end

    assign turnCw = turnCw_ff;
    assign keypadFaultDisp = keypad_ff;

    sbc_pulse_out pulseGen (
        .clk(clk),
        .srst(srst),
        .stepPulse(stepPulse),
        .stepFwd(stepFwd),
        .phaseLag(cfg_ff[IX_PHASE][0]),
        .pulseA(pulseA),
        .pulseB(pulseB)
    );

    // ==========================================================
    // Stop cause resolution, highest priority first
    localparam sbc_action_t NO_ACTION = '{valid: 1'b0, decel: DEC_NONE, hold: HOLD_DEENERG};
    wire sbc_action_t mainsAct = (mainsSel == 16'h0001) ? decodeClass2(cfg_ff[IX_C2]) :
                                 (mainsSel == 16'h0002) ? decodeServoOff(cfg_ff[IX_SOFF]) :
                                 (mainsSel == 16'h0003) ? decodeQuick(cfg_ff[IX_QS]) :
                                 NO_ACTION;
    wire ovtLive = overtravel && (cfg_ff[IX_OVT] != `SBC_OVT_IGNORE);
    wire sbc_action_t stopNow =
        fault1 ? decodeClass1(cfg_ff[IX_C1]) :
        fault2 ? decodeClass2(cfg_ff[IX_C2]) :
        (mainsLoss && mainsAct.valid) ? mainsAct :
        ovtLive ? decodeOvertravel(cfg_ff[IX_OVT]) :
        quickStop ? decodeQuick(cfg_ff[IX_QS]) :
        !servoEnableCmd ? decodeServoOff(cfg_ff[IX_SOFF]) : NO_ACTION;

    // ==========================================================
    // Stop and brake sequencer
    sbc_state_t nxt_state;
    sbc_action_t action_ff;
    sbc_action_t nxt_action;
    logic brake_ff;
    logic nxt_brake;
    logic [15:0] msDiv_ff;
    logic [15:0] msCnt_ff;
    logic energ_ff;
    logic dynBrk_ff;
    logic posLock_ff;
    sbc_decel_t decel_ff;
    logic accept_ff;
    logic stopAct_ff;

    wire standstill = (motorSpeedRpm == 16'h0000);
    wire msTick = (msDiv_ff == MS_LAST);
    wire onDone = (msCnt_ff >= bkOnDly);
    wire offDone = (msCnt_ff >= bkOffDly);
    wire rotRelease = (motorSpeedRpm < bkSpdThr) || (msCnt_ff >= bkRotDly);
    wire decelPowered = (action_ff.decel != DEC_COAST) && (action_ff.decel != DEC_DYNBRK);

    always_comb begin
        nxt_state = state_ff;
        nxt_action = action_ff;
        nxt_brake = brake_ff;
        case (state_ff)
            S_OFF: begin
                if (servoEnableCmd && !stopNow.valid) begin
                    nxt_state = S_BKON;
                    nxt_brake = 1'b1;
                end
            end
            S_BKON, S_RUN: begin
                if (stopNow.valid) begin
                    nxt_action = stopNow;
                    // Standstill skips deceleration and drops the brake at once
                    nxt_state = standstill ? S_BKOFF : S_DECEL;
                    nxt_brake = !standstill;
                end else if (state_ff == S_BKON && onDone) begin
                    nxt_state = S_RUN;
                end
            end
            S_DECEL: begin
                if (brake_ff && rotRelease) begin
                    nxt_brake = 1'b0;
                end
                if (standstill && !brake_ff) begin
                    nxt_state = S_HOLD;
                end
            end
            S_BKOFF: begin
                if (offDone) begin
                    nxt_state = S_HOLD;
                end
            end
            S_HOLD: begin
                if (!stopNow.valid) begin
                    nxt_state = S_BKON;
                    nxt_brake = 1'b1;
                end else if (action_ff.hold != HOLD_POSLOCK || !servoEnableCmd) begin
                    nxt_state = S_OFF;
                end
            end
            default: begin
                nxt_state = S_OFF;
                nxt_brake = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= S_OFF;
            action_ff <= NO_ACTION;
            brake_ff <= 1'b0;
            msDiv_ff <= 16'h0000;
            msCnt_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            action_ff <= nxt_action;
            brake_ff <= nxt_brake;
            msDiv_ff <= msTick ? 16'h0000 : msDiv_ff + 16'h0001;
            // Millisecond count restarts on every state change
            if (nxt_state != state_ff) begin
                msCnt_ff <= 16'h0000;
            end else if (msTick && msCnt_ff != `SBC_CNT_MAX) begin
                msCnt_ff <= msCnt_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            energ_ff <= 1'b0;
            dynBrk_ff <= 1'b0;
            posLock_ff <= 1'b0;
            decel_ff <= DEC_NONE;
            accept_ff <= 1'b0;
            stopAct_ff <= 1'b0;
        end else begin
            energ_ff <= (state_ff == S_BKON) || (state_ff == S_RUN) || (state_ff == S_BKOFF) ||
                        (state_ff == S_DECEL && decelPowered) ||
                        (state_ff == S_HOLD && action_ff.hold == HOLD_POSLOCK);
            dynBrk_ff <= (state_ff == S_DECEL && action_ff.decel == DEC_DYNBRK) ||
                         ((state_ff == S_HOLD || state_ff == S_OFF) &&
                          action_ff.valid && action_ff.hold == HOLD_DYNBRK);
            posLock_ff <= (state_ff == S_HOLD) && (action_ff.hold == HOLD_POSLOCK);
            decel_ff <= (state_ff == S_DECEL) ? action_ff.decel : DEC_NONE;
            accept_ff <= (state_ff == S_RUN);
            stopAct_ff <= (state_ff == S_DECEL) || (state_ff == S_BKOFF) || (state_ff == S_HOLD);
        end
    end

    assign parRdData = parRdData_ff;
    assign parAck = parAck_ff;
    assign parErr = parErr_ff;
    assign brake_output = brake_ff;
    assign motorEnergized = energ_ff;
    assign dynBrakeOn = dynBrk_ff;
    assign positionLock = posLock_ff;
    assign decelMode = decel_ff;
    assign cmdAccept = accept_ff;
    assign stopActive = stopAct_ff;

endmodule : sbc_params

`default_nettype wire

// >>> sbc_consts.svh
// Constants for the servo basic control parameter bank: offsets, resets, limits, timing.
// Assumes a 40 MHz clock; included by the package and the parameter bank module.
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH

// ==========================================================
// Timing
`define SBC_CLK_PERIOD_NS 25
`define SBC_MS_NS 1000000
`define SBC_MS_CYCLES (`SBC_MS_NS / `SBC_CLK_PERIOD_NS)
`define SBC_CNT_MAX 16'hffff

// ==========================================================
// Parameter word offsets
`define SBC_NUM_RW 15
`define SBC_A_CTRL 16'h0200
`define SBC_A_ABS 16'h0201
`define SBC_A_DIR 16'h0202
`define SBC_A_PHASE 16'h0203
`define SBC_A_SOFF 16'h0205
`define SBC_A_C2 16'h0206
`define SBC_A_OVT 16'h0207
`define SBC_A_C1 16'h0208
`define SBC_A_BKON 16'h0209
`define SBC_A_BKOFF 16'h020a
`define SBC_A_BKSPD 16'h020b
`define SBC_A_BKROT 16'h020c
`define SBC_A_KPD 16'h020f
`define SBC_A_MAINS 16'h0211
`define SBC_A_QS 16'h0212
`define SBC_A_REGEN_RES 16'h0215
`define SBC_A_REGEN_PWR 16'h0216

// ==========================================================
// Reset values
`define SBC_R_CTRL 16'h0001
`define SBC_R_ABS 16'h0000
`define SBC_R_DIR 16'h0000
`define SBC_R_PHASE 16'h0000
`define SBC_R_SOFF 16'h0000
`define SBC_R_C2 16'h0002
`define SBC_R_OVT 16'h0001
`define SBC_R_C1 16'h0002
`define SBC_R_BKON 16'h00fa
`define SBC_R_BKOFF 16'h0096
`define SBC_R_BKSPD 16'h001e
`define SBC_R_BKROT 16'h01f4
`define SBC_R_KPD 16'h0000
`define SBC_R_MAINS 16'h0002
`define SBC_R_QS 16'h0002
`define SBC_V_REGEN_RES 16'h0028
`define SBC_V_REGEN_PWR 16'h0032

// ==========================================================
// Write limits (signed selectors in two's complement)
`define SBC_MIN_ZERO 16'h0000
`define SBC_MAX_CTRL 16'h0007
`define SBC_MAX_ABS 16'h0004
`define SBC_MAX_BIT 16'h0001
`define SBC_MIN_SOFF 16'hfffc
`define SBC_MAX_SOFF 16'h0002
`define SBC_MIN_C2 16'hfffb
`define SBC_MAX_C2 16'h0004
`define SBC_MAX_OVT 16'h0007
`define SBC_MAX_C1 16'h0002
`define SBC_MAX_BKON 16'h01f4
`define SBC_MIN_BKOFF 16'h0032
`define SBC_MAX_BKOFF 16'h03e8
`define SBC_MIN_BKSPD 16'h0014
`define SBC_MAX_BKSPD 16'h0bb8
`define SBC_MIN_BKROT 16'h0001
`define SBC_MAX_BKROT 16'hffff
`define SBC_MAX_MAINS 16'h0003
`define SBC_MAX_QS 16'h0007
`define SBC_QS_UNASSIGNED 16'h0004
`define SBC_OVT_IGNORE 16'h0007

// Index masks: writable only at stop, and signed comparison
`define SBC_AT_STOP_MASK 15'h00cf
`define SBC_SIGNED_MASK 15'h0030

`endif

// >>> sbc_pkg.sv
// Types for the servo basic control parameter bank.
// Assumes sbc_consts.svh is on the include path.
`include "sbc_consts.svh"

package sbc_pkg;

    // ==========================================================
    // Register indices
    typedef enum logic [3:0] {
        IX_CTRL, IX_ABS, IX_DIR, IX_PHASE, IX_SOFF, IX_C2, IX_OVT, IX_C1,
        IX_BKON, IX_BKOFF, IX_BKSPD, IX_BKROT, IX_KPD, IX_MAINS, IX_QS
    } sbc_idx_t;

    // ==========================================================
    // Stop actions
    typedef enum logic [2:0] {
        DEC_NONE, DEC_COAST, DEC_DYNBRK, DEC_ZEROSPD, DEC_RAMP1, DEC_RAMP2, DEC_EMTORQ
    } sbc_decel_t;

    typedef enum logic [1:0] {
        HOLD_DEENERG, HOLD_DYNBRK, HOLD_POSLOCK
    } sbc_hold_t;

    typedef struct packed {
        logic valid;
        sbc_decel_t decel;
        sbc_hold_t hold;
    } sbc_action_t;

    typedef enum logic [5:0] {
        S_OFF = 6'h01,
        S_BKON = 6'h02,
        S_RUN = 6'h04,
        S_DECEL = 6'h08,
        S_BKOFF = 6'h10,
        S_HOLD = 6'h20
    } sbc_state_t;

endpackage : sbc_pkg

// >>> sbc_pulse_out.sv
// Quadrature generator for the frequency-divided encoder output.
// Assumes one step pulse per output edge, already divided down.
`timescale 1ns/1ps
`default_nettype none

module sbc_pulse_out (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Step input
    input wire logic stepPulse,
    input wire logic stepFwd,
    input wire logic phaseLag,
    // Quadrature output
    output logic pulseA,
    output logic pulseB
);
    import sbc_pkg::*;

    logic [1:0] quad_ff;
    logic [1:0] nxt_quad;
    logic aLead;
    logic bLead;
    logic pulseA_ff;
    logic pulseB_ff;

    // Sequence 0,1,2,3 gives (A,B) = 00,10,11,01: A rises first
    assign nxt_quad = !stepPulse ? quad_ff : stepFwd ? quad_ff + 2'h1 : quad_ff - 2'h1;
    assign aLead = nxt_quad[1] ^ nxt_quad[0];
    assign bLead = nxt_quad[1];

    always_ff @(posedge clk) begin
        if (srst) begin
            quad_ff <= 2'h0;
            pulseA_ff <= 1'b0;
            pulseB_ff <= 1'b0;
        end else begin
            quad_ff <= nxt_quad;
            pulseA_ff <= phaseLag ? bLead : aLead;
            pulseB_ff <= phaseLag ? aLead : bLead;
        end
    end

    assign pulseA = pulseA_ff;
    assign pulseB = pulseB_ff;

endmodule : sbc_pulse_out

`default_nettype wire

// >>> sbc_params_chk.sv
// Port assertions for the parameter bank.
// Assumes one clock domain with srst synchronous.
`timescale 1ns/1ps
`default_nettype none
module sbc_params_chk (
    input wire logic clk, srst, parWrEn, parRdEn, parAck, parErr, stepPulse, pulseA, pulseB,
    input wire logic [15:0] parAddr, parWrData, motorSpeedRpm,
    input wire logic servoEnableCmd, fault1, fault2, fault3, overtravel, quickStop, mainsLoss,
    input wire logic brake_output, motorEnergized, cmdAccept, keypadFaultDisp, stopActive
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire noCause = !(fault1 | fault2 | overtravel | quickStop | mainsLoss);
    sequence s_req; parWrEn || parRdEn; endsequence
    sequence s_bk_up; $rose(brake_output) ##1 motorEnergized; endsequence
    a_ack_timing: assert property (s_req |=> parAck)
        else $error("request without ack");
    a_err_ack: assert property (parErr |-> parAck) else $error("error without ack");
    a_ro_refused: assert property (parWrEn && parAddr inside {16'h0215, 16'h0216}
        |=> parErr) else $error("read-only write taken");
    a_qs_unassigned: assert property (parWrEn && parAddr == 16'h0212
        && parWrData == 16'h0004 |=> parErr) else $error("quick stop code 4 taken");
    a_brake_start: assert property ($rose(servoEnableCmd) && noCause && !stopActive
        && !motorEnergized |-> ##[1:2] s_bk_up) else $error("brake on sequence wrong");
    a_brake_drop: assert property (!servoEnableCmd && cmdAccept && motorSpeedRpm == 16'h0
        && noCause |-> ##[1:2] !brake_output) else $error("brake kept on");
    a_keypad_cause: assert property ($rose(keypadFaultDisp) |-> $past(fault3))
        else $error("keypad without fault");
    a_quad_gray: assert property ($past(stepPulse) |-> $stable(pulseA) ^ $stable(pulseB))
        else $error("step not one edge");
endmodule : sbc_params_chk
bind sbc_params sbc_params_chk u_chk (.*);
`default_nettype wire

// >>> sbc_host_model.sv
// Host controller model issuing single parameter words.
// Assumes requests taken on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module sbc_host_model (
    input wire logic clk,
    output logic parWrEn, parRdEn,
    output logic [15:0] parAddr, parWrData
);
    initial {parWrEn, parRdEn, parAddr, parWrData} = 34'h0;
    // Idle lines scrambled so stale values never look valid
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        {parWrEn, parRdEn, parAddr, parWrData} = {w, !w, a, d};
        @(negedge clk);
        {parWrEn, parRdEn, parAddr, parWrData} = {2'b00, ~a, ~d};
    endtask : xfer
endmodule : sbc_host_model
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the parameter bank.
// Assumes MS_CYCLES of 4, so one ms is four clocks.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, srst, parAck, parErr, servoEnableCmd, fault1, fault2, fault3, overtravel;
    logic quickStop, mainsLoss, forwardCmd, stepPulse, stepFwd, pulseA, pulseB, parWrEn, parRdEn;
    logic keypadFaultDisp, brake_output, motorEnergized, cmdAccept, tc;
    logic [2:0] cm, ab;
    logic [15:0] parAddr, parWrData, parRdData, motorSpeedRpm, v, sp;
    logic [17:0] e;
    logic [17:0] expQ[$];
    int err_count = 0, check_count = 0, seed = 38030, n;
    localparam logic [7:0] OF[17] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h08,
        8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0f, 8'h11, 8'h12, 8'h15, 8'h16};
    localparam logic [15:0] RS[17] = '{16'h1, 16'h0, 16'h0, 16'h0, 16'h0, 16'h2, 16'h1, 16'h2,
        16'hfa, 16'h96, 16'h1e, 16'h1f4, 16'h0, 16'h2, 16'h2, 16'h28, 16'h32};
    localparam logic [15:0] LO[15] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'hfffc, 16'hfffb, 16'h0,
        16'h0, 16'h0, 16'h32, 16'h14, 16'h1, 16'h0, 16'h0, 16'h0};
    localparam logic [15:0] HI[15] = '{16'h7, 16'h4, 16'h1, 16'h1, 16'h2, 16'h4, 16'h7, 16'h2,
        16'h1f4, 16'h3e8, 16'hbb8, 16'hffff, 16'h1, 16'h3, 16'h7};
    localparam logic [15:0] BAD[15] = '{16'h8, 16'h5, 16'h2, 16'h2, 16'hfffb, 16'h5, 16'h8,
        16'h3, 16'h1f5, 16'h31, 16'h13, 16'h0, 16'h2, 16'h4, 16'h4};
    sbc_params #(.MS_CYCLES(4)) u_dut (.clk, .srst, .parWrEn, .parRdEn, .parAddr, .parWrData,
        .parRdData, .parAck, .parErr, .servoEnableCmd, .fault1, .fault2, .fault3, .overtravel,
        .quickStop, .mainsLoss, .motorSpeedRpm, .forwardCmd, .stepPulse, .stepFwd, .pulseA,
        .pulseB, .controlMode(cm), .absSystem(ab), .turnCw(tc), .keypadFaultDisp, .brake_output,
        .motorEnergized, .dynBrakeOn(), .positionLock(), .decelMode(), .cmdAccept,
        .stopActive());
    sbc_host_model u_host (.clk, .parWrEn, .parRdEn, .parAddr, .parWrData);
    // ====================
    // Tasks
    task automatic check(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : check
    task automatic acc(input logic w, input logic [15:0] a, d, input logic er, input logic [15:0] x);
        expQ.push_back({w, er, x});
        u_host.xfer(w, a, d);
    endtask : acc
    task automatic wt(input logic useEn, input logic lvl, output int c);
        c = 0;
        while ((useEn ? motorEnergized : cmdAccept) !== lvl) begin
            @(negedge clk);
            c++;
            if (c > 400) begin
                check(1'b0, "wait timed out");
                results();
            end
        end
    endtask : wt
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    // ====================
    // Answer monitor
    always @(negedge clk) begin
        if (parAck === 1'b1) begin
            e = (expQ.size() > 0) ? expQ.pop_front() : 18'hx;
            check(parErr === e[16] && (e[17] || parRdData === e[15:0]), "bus answer");
        end
    end
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {srst, servoEnableCmd, fault1, fault2, fault3, overtravel, quickStop} = 7'h40;
        {mainsLoss, forwardCmd, stepPulse, stepFwd, motorSpeedRpm} = 20'h0;
        repeat (12) @(negedge clk);
        srst = 1'b0;
        for (int i = 0; i < 17; i++) acc(1'b0, {8'h02, OF[i]}, 16'h0, 1'b0, RS[i]);
        check(cm === 3'h1 && ab === 3'h0 && tc === 1'b1, "config defaults");
        $display("reset values done");
        for (int i = 0; i < 15; i++) begin
            sp = HI[i] - LO[i] + 16'h1;
            v = LO[i] + 16'($unsigned($random(seed)) % sp);
            acc(1'b1, {8'h02, OF[i]}, v, i == 14 && v == 16'h4, 16'h0);
            acc(1'b1, {8'h02, OF[i]}, BAD[i], 1'b1, 16'h0);
            acc(1'b0, {8'h02, OF[i]}, 16'h0, 1'b0, (i == 14 && v == 16'h4) ? RS[i] : v);
        end
        acc(1'b1, 16'h0215, 16'h1, 1'b1, 16'h0);
        acc(1'b0, 16'h0215, 16'h0, 1'b0, 16'h28);
        acc(1'b0, 16'h0204, 16'h0, 1'b1, 16'h0);
        $display("ranges done");
        acc(1'b1, 16'h0209, 16'h3, 1'b0, 16'h0);
        acc(1'b1, 16'h020a, 16'h32, 1'b0, 16'h0);
        acc(1'b1, 16'h0205, 16'h0, 1'b0, 16'h0);
        acc(1'b1, 16'h020f, 16'h0, 1'b0, 16'h0);
        servoEnableCmd = 1'b1;
        wt(1'b0, 1'b1, n);
        check(n >= 12 && n <= 20, "command delay");
        acc(1'b1, 16'h0200, 16'h0, 1'b1, 16'h0);
        acc(1'b1, 16'h020b, 16'h14, 1'b0, 16'h0);
        servoEnableCmd = 1'b0;
        wt(1'b1, 1'b0, n);
        check(n >= 200 && n <= 210, "de-energize delay");
        $display("sequencer done");
        fault3 = 1'b1;
        repeat (3) @(negedge clk);
        check(keypadFaultDisp === 1'b1, "keypad not set");
        fault3 = 1'b0;
        acc(1'b1, 16'h020f, 16'h1, 1'b0, 16'h0);
        fault3 = 1'b1;
        repeat (3) @(negedge clk);
        check(keypadFaultDisp === 1'b0, "keypad not suppressed");
        repeat (20) begin
            @(negedge clk);
            {stepPulse, stepFwd, forwardCmd, motorSpeedRpm} = 19'($random(seed));
        end
        repeat (3) @(negedge clk);
        check(expQ.size() == 0, "answers missing");
        $display("keypad and pulses done");
        results();
    end
endmodule : tb
`default_nettype wire
